// ---- core/swi_core.sv ----
// module: secure element wired interface core (signal shaping, counters, registers)
//
// How it works
// - wired card: internal clock drives signal-out
// - card emulation: field clock and data
// - signal-in accepts type F or A
// - type F out = carrier xor data
// - demod data filtered, about one bit
// - filtered data changes on carrier rise
// - type F signal-in goes to driver
// - carrier on aux pin when enabled
// - signal-in sampled on common carrier clock
// - type A out is miller coded carrier
// - route select sets signal-out content
// - two filtered counters, 127 and 31
// - select bit: 0 picks 31, 1 127
// - enable bit runs counters, 2-12 MHz; code counts rise-to-rise periods of 10-51 clocks, about 2-10 MHz
// - flag at limit, interrupt when enabled
// - idle mask: signal-in 0, aux 1
// - driver mix: signal-in and coder drive
//
// Added by the designer: strobed register access.
module swi_core
  import swi_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output      logic [7:0]  RD_DATA,
  input  wire logic        OSC_CLK,
  input  wire logic        FIELD_CLK,
  input  wire logic        DEMOD_DATA,
  input  wire logic        CODER_OUT,
  input  wire logic        SECURE_IN_LINE,
  output      logic        SECURE_OUT_LINE,
  input  wire logic        AUX_CLOCK_PIN_I,
  output      logic        AUX_CLOCK_PIN_O,
  output      logic        AUX_CLOCK_PIN_OE,
  output      logic        ANTENNA_MOD,
  output      logic        IRQ
);
  import swi_pkg::*;

  // ==================== synchronisers ====================
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] async_in;
  assign async_in = {AUX_CLOCK_PIN_I, SECURE_IN_LINE, DEMOD_DATA, FIELD_CLK, OSC_CLK};

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire osc_s   = sync2_reg[0];
  wire field_s = sync2_reg[1];
  wire demod_s = sync2_reg[2];
  wire sin_s   = sync2_reg[3];
  wire aux_s   = sync2_reg[4];

  // ==================== registers ====================
  swi_bus_req_t   req;
  swi_route_cfg_t cfg_reg;
  logic [7:0]     ctrl_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic [7:0]     rx_data_reg;
  logic [7:0]     rd_data_reg;
  logic [IRQ_WIDTH-1:0] irq_event;
  logic           limit_hit;

  assign req = '{addr: ADDR, wdata: WR_DATA, wr: WR_EN, rd: RD_EN};

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    return a == base;
  endfunction

  wire wr_ctrl   = req.wr && hit(req.addr, ADDR_WIRE_CTRL);
  wire wr_cfg    = req.wr && hit(req.addr, ADDR_ROUTE_CFG);
  wire wr_status = req.wr && hit(req.addr, ADDR_IRQ_STATUS);
  wire wr_mask   = req.wr && hit(req.addr, ADDR_IRQ_MASK);

  wire cnt_enable = ctrl_reg[BIT_CNT_ENABLE];
  wire cnt_select = ctrl_reg[BIT_CNT_SELECT];
  wire ctrl_en_next = wr_ctrl ? req.wdata[BIT_CNT_ENABLE] : cnt_enable;

  logic [7:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = (ctrl_reg & ~WIRE_CTRL_WMASK) | (req.wdata & WIRE_CTRL_WMASK);
    end
    if (!ctrl_en_next) begin
      ctrl_next[BIT_CNT_FLAG] = 1'b0;
    end else if (limit_hit) begin
      ctrl_next[BIT_CNT_FLAG] = 1'b1;
    end
  end

  // set wins over write-one-to-clear
  wire [IRQ_WIDTH-1:0] irq_status_next =
    (irq_status_reg & ~(wr_status ? req.wdata[IRQ_WIDTH-1:0] : '0)) | irq_event;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_reg       <= WIRE_CTRL_RESET;
      cfg_reg        <= ROUTE_CFG_RESET;
      irq_status_reg <= '0;
      irq_mask_reg   <= IRQ_MASK_RESET[IRQ_WIDTH-1:0];
    end else begin
      ctrl_reg       <= ctrl_next;
      irq_status_reg <= irq_status_next;
      if (wr_cfg) begin
        cfg_reg <= req.wdata;
      end
      if (wr_mask) begin
        irq_mask_reg <= req.wdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // counter interrupt enable sits in the mask register bit 0
  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // ==================== carrier selection ====================
  logic carrier_d_reg;
  wire  carrier_lvl  = cfg_reg.secure_clock_source_choice ? osc_s : field_s;
  wire  carrier_rise = carrier_lvl && !carrier_d_reg;

  // ==================== demod filter ====================
  logic [$clog2(FILT_CYC+1)-1:0] filt_cnt_reg;
  logic filt_out_reg;
  logic demod_lat_reg;
  logic out_reg;
  logic sin_lat_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      filt_cnt_reg  <= '0;
      filt_out_reg  <= 1'b0;
    end else begin
      if (demod_s && filt_cnt_reg != FILT_CYC[$bits(filt_cnt_reg)-1:0]) begin
        filt_cnt_reg <= filt_cnt_reg + 1'b1;
      end else if (!demod_s && filt_cnt_reg != '0) begin
        filt_cnt_reg <= filt_cnt_reg - 1'b1;
      end
      if (filt_cnt_reg == FILT_CYC[$bits(filt_cnt_reg)-1:0]) begin
        filt_out_reg <= 1'b1;
      end else if (filt_cnt_reg == '0) begin
        filt_out_reg <= 1'b0;
      end
    end
  end

  // ==================== signal-out shaping ====================
  wire sin_view = cfg_reg.idle_mask ? 1'b0 : sin_s;
  wire aux_view = cfg_reg.idle_mask ? 1'b1 : aux_s;
  // miller pauses come from the internal coder in wired card, field otherwise
  wire miller_pause = cfg_reg.secure_clock_source_choice ? CODER_OUT : demod_s;

  logic out_next;
  always_comb begin
    case (cfg_reg.tx_route_select)
      TX_ROUTE_XOR:    out_next = carrier_lvl ^ demod_lat_reg;
      TX_ROUTE_MILLER: out_next = carrier_lvl & !miller_pause;
      TX_ROUTE_RAW:    out_next = CODER_OUT;
      default:         out_next = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      carrier_d_reg <= 1'b0;
      demod_lat_reg <= 1'b0;
      sin_lat_reg   <= 1'b0;
      out_reg       <= 1'b0;
    end else begin
      carrier_d_reg <= carrier_lvl;
      out_reg       <= out_next;
      if (carrier_rise) begin
        demod_lat_reg <= filt_out_reg;
        sin_lat_reg   <= sin_view;
      end
    end
  end

  assign SECURE_OUT_LINE  = out_reg;
  assign AUX_CLOCK_PIN_O  = carrier_d_reg;
  assign AUX_CLOCK_PIN_OE = cfg_reg.aux_clock_route_enable;

  // ==================== antenna driver path ====================
  logic ant_reg;
  wire  ant_next = cfg_reg.driver_mix_enable ? (sin_lat_reg | CODER_OUT) :
                   (cfg_reg.tx_route_select == TX_ROUTE_XOR) ? sin_lat_reg :
                   CODER_OUT;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ant_reg <= 1'b0;
    end else begin
      ant_reg <= ant_next;
    end
  end
  assign ANTENNA_MOD = ant_reg;

  // ==================== filtered request counters ====================
  logic sin_d_reg;
  logic [$clog2(PER_MAX_CYC+2)-1:0] per_reg;
  wire  sin_rise = sin_view && !sin_d_reg;
  wire  per_ok   = per_reg >= PER_MIN_CYC[$bits(per_reg)-1:0] &&
                   per_reg <= PER_MAX_CYC[$bits(per_reg)-1:0];
  wire  per_long = per_reg > PER_MAX_CYC[$bits(per_reg)-1:0];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sin_d_reg <= 1'b0;
      per_reg   <= '0;
    end else begin
      sin_d_reg <= sin_view;
      if (sin_rise) begin
        per_reg <= '0;
      end else if (!per_long) begin
        per_reg <= per_reg + 1'b1;
      end
    end
  end

  localparam int NCNT = 2;
  localparam logic [6:0] CNT_LIMITS [NCNT] = '{7'(CNT_LIMIT_SHORT), 7'(CNT_LIMIT_LONG)};
  logic [NCNT-1:0] at_limit;

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++) begin : g_cnt
      logic [6:0] cnt_reg;
      always_ff @(posedge CLK_SYS) begin
        if (RST || !cnt_enable) begin
          cnt_reg <= '0;
        end else if (per_long) begin
          cnt_reg <= '0;
        end else if (sin_rise && per_ok && cnt_reg != CNT_LIMITS[gi]) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign at_limit[gi] = cnt_reg == CNT_LIMITS[gi];
    end
  endgenerate

  logic sel_lim_d_reg;
  wire  sel_lim = cnt_enable && (cnt_select ? at_limit[1] : at_limit[0]);
  assign limit_hit = sel_lim && !sel_lim_d_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sel_lim_d_reg <= 1'b0;
    end else begin
      sel_lim_d_reg <= sel_lim;
    end
  end

  // ==================== manchester subcarrier decoder ====================
  swi_dec_state_t dec_state_reg;
  swi_dec_state_t dec_state_next;
  logic [6:0] edge_cnt_reg;
  logic       act_reg;
  logic       first_act_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       byte_ev_reg;
  logic       end_ev_reg;

  wire dec_on   = cfg_reg.scheme_a;
  wire half_end = carrier_rise && edge_cnt_reg == 7'(HALF_BIT_EDGES - 1);
  wire act_now  = act_reg || sin_rise;

  always_comb begin
    dec_state_next = dec_state_reg;
    case (dec_state_reg)
      DEC_IDLE:   if (dec_on && sin_rise) dec_state_next = DEC_FIRST;
      DEC_FIRST:  if (half_end) dec_state_next = DEC_SECOND;
      DEC_SECOND: if (half_end) dec_state_next = (!first_act_reg && !act_reg) ? DEC_IDLE : DEC_FIRST;
      default:    dec_state_next = DEC_IDLE;
    endcase
    if (!dec_on) begin
      dec_state_next = DEC_IDLE;
    end
  end

  wire bit_done = dec_state_reg == DEC_SECOND && half_end && (first_act_reg ^ act_reg);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dec_state_reg <= DEC_IDLE;
      edge_cnt_reg  <= '0;
      act_reg       <= 1'b0;
      first_act_reg <= 1'b0;
      shift_reg     <= '0;
      bit_cnt_reg   <= '0;
      rx_data_reg   <= '0;
      byte_ev_reg   <= 1'b0;
      end_ev_reg    <= 1'b0;
    end else begin
      dec_state_reg <= dec_state_next;
      byte_ev_reg   <= 1'b0;
      end_ev_reg    <= 1'b0;
      if (dec_state_reg == DEC_IDLE) begin
        edge_cnt_reg <= '0;
        act_reg      <= sin_rise;   // the rise that opens a frame belongs to its first half
        bit_cnt_reg  <= '0;
      end else begin
        if (carrier_rise) begin
          edge_cnt_reg <= half_end ? '0 : edge_cnt_reg + 1'b1;
        end
        // a rise on the half boundary opens the next half
        act_reg <= half_end ? sin_rise : act_now;
        if (half_end && dec_state_reg == DEC_FIRST) begin
          first_act_reg <= act_reg;
        end
        if (bit_done) begin
          shift_reg   <= {first_act_reg, shift_reg[7:1]};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
          if (bit_cnt_reg == 3'h7) begin
            rx_data_reg <= {first_act_reg, shift_reg[7:1]};
            byte_ev_reg <= 1'b1;
          end
        end
        if (dec_state_next == DEC_IDLE) begin
          end_ev_reg <= 1'b1;
        end
      end
    end
  end

  assign irq_event = {end_ev_reg, byte_ev_reg, limit_hit};

  // ==================== read port ====================
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      ADDR_WIRE_CTRL:  rd_mux = ctrl_reg;
      ADDR_ROUTE_CFG:  rd_mux = cfg_reg;
      ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_status_reg};
      ADDR_IRQ_MASK:   rd_mux = {5'h00, irq_mask_reg};
      ADDR_RX_DATA:    rd_mux = rx_data_reg;
      ADDR_LINE_STATE: rd_mux = {4'h0, aux_view, sin_view, demod_lat_reg, carrier_lvl};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= req.rd ? rd_mux : 8'h00;
    end
  end
  assign RD_DATA = rd_data_reg;

endmodule // swi_core

// ---- dv/swi_se_model.sv ----
// model of the secure element sending request pulses on signal-in
module swi_se_model (
  input  wire logic       clk_carrier,
  input  wire logic       go,
  input  wire logic       manch,
  input  wire logic [7:0] n_pulses,
  output      logic       sig_in,
  output      logic       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================== pulse train ====================
  initial begin
    sig_in = 1'b0;
    busy = 1'b0;
  end
  // one half bit: four subcarrier periods of 16 carrier cycles, high first when active
  task automatic send_half(input logic act);
    repeat (4) begin
      @(posedge clk_carrier) sig_in <= act;
      repeat (7) @(posedge clk_carrier);
      @(posedge clk_carrier) sig_in <= 1'b0;
      repeat (7) @(posedge clk_carrier);
    end
  endtask
  // pulses timed on the common carrier, one carrier period high and low
  // in manchester mode n_pulses holds the byte, sent lsb first
  always @(posedge go) begin
    busy = 1'b1;
    if (manch) begin
      for (int i = 0; i < 8; i++) begin
        send_half(n_pulses[i]);
        send_half(!n_pulses[i]);
      end
    end else begin
      repeat (n_pulses) begin
        @(posedge clk_carrier) sig_in <= 1'b1;
        @(posedge clk_carrier) sig_in <= 1'b0;
      end
    end
    busy = 1'b0;
  end
endmodule // swi_se_model

// ---- dv/swi_sva.sv ----
// checker: bus, interrupt and pin relations of the secure wired interface
module swi_sva
  import swi_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WR_DATA,
  input wire logic        WR_EN,
  input wire logic        RD_EN,
  input wire logic [7:0]  RD_DATA,
  input wire logic        SECURE_OUT_LINE,
  input wire logic        AUX_CLOCK_PIN_OE,
  input wire logic        IRQ
);
  import swi_pkg::*;
  // ==================== shadow of written registers ====================
  logic [7:0] cfg_reg;
  logic [2:0] mask_reg;
  wire        mapped = (ADDR == ADDR_WIRE_CTRL) || (ADDR >= ADDR_ROUTE_CFG && ADDR <= ADDR_LINE_STATE);
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cfg_reg  <= 8'h00;
      mask_reg <= 3'h0;
    end else if (WR_EN && ADDR == ADDR_ROUTE_CFG) begin
      cfg_reg <= WR_DATA;
    end else if (WR_EN && ADDR == ADDR_IRQ_MASK) begin
      mask_reg <= WR_DATA[2:0];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_rd(logic [15:0] a);
    RD_EN && ADDR == a ##1 1'b1;
  endsequence
  a_rd_quiet_zero: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00) else $error("read data outside window");
  a_unmapped_zero: assert property (RD_EN && !mapped ##1 1'b1 |-> RD_DATA == 8'h00) else $error("unmapped read");
  a_ctrl_rsvd_zero: assert property (s_rd(ADDR_WIRE_CTRL) |-> RD_DATA[7:4] == 4'h0) else $error("ctrl reserved");
  a_flag_needs_en: assert property (s_rd(ADDR_WIRE_CTRL) |-> !RD_DATA[3] || RD_DATA[0]) else $error("flag w/o en");
  a_irq_masked: assert property (IRQ |-> mask_reg != 3'h0 || $past(mask_reg) != 3'h0) else $error("irq masked");
  a_irq_stays: assert property (IRQ && !WR_EN |=> IRQ) else $error("irq dropped without write");
  a_oe_follows_cfg: assert property (WR_EN && ADDR == ADDR_ROUTE_CFG |=> AUX_CLOCK_PIN_OE == $past(WR_DATA[3]))
    else $error("aux enable");
  a_out_off_quiet: assert property (cfg_reg[1:0] == TX_ROUTE_OFF && $past(cfg_reg[1:0]) == TX_ROUTE_OFF
    |-> !SECURE_OUT_LINE) else $error("signal-out active while off");
  a_idle_mask_view: assert property (s_rd(ADDR_LINE_STATE) |-> !cfg_reg[5] || !$past(cfg_reg[5], 4)
    || (!RD_DATA[2] && RD_DATA[3])) else $error("idle mask view");
endmodule // swi_sva

bind swi_core swi_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SECURE_OUT_LINE(SECURE_OUT_LINE), .AUX_CLOCK_PIN_OE(AUX_CLOCK_PIN_OE), .IRQ(IRQ));

// ---- dv/testbench.sv ----
// testbench: register, counter, interrupt and signal-out scenarios
module testbench;
  import swi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==================== stimulus and design ====================
  logic CLK_SYS = 1'b0, RST = 1'b1, osc = 1'b0, wr_en = 1'b0, rd_en = 1'b0, demod = 1'b0, aux_i = 1'b0, se_go = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, se_n = 8'h00, rd_data;
  logic out_line, aux_o, aux_oe, irq, se_line, se_busy, ant;
  logic se_manch = 1'b0, ant_d = 1'b0;
  int ant_rises = 0;
  int miscompares = 0, cmp_count = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  always #40 osc = ~osc;
  swi_core dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
    .RD_DATA(rd_data), .OSC_CLK(osc), .FIELD_CLK(1'b0), .DEMOD_DATA(demod), .CODER_OUT(1'b0),
    .SECURE_IN_LINE(se_line), .SECURE_OUT_LINE(out_line), .AUX_CLOCK_PIN_I(aux_i), .AUX_CLOCK_PIN_O(aux_o),
    .AUX_CLOCK_PIN_OE(aux_oe), .ANTENNA_MOD(ant), .IRQ(irq));
  swi_se_model u_se (.clk_carrier(osc), .go(se_go), .manch(se_manch), .n_pulses(se_n), .sig_in(se_line),
    .busy(se_busy));
  // count antenna pulses, sampled away from the launching edge
  always @(negedge CLK_SYS) begin
    ant_d <= ant;
    if (ant === 1'b1 && ant_d === 1'b0) ant_rises <= ant_rises + 1;
  end
  // ==================== tasks ====================
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge CLK_SYS);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge CLK_SYS);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge CLK_SYS);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic send(logic [7:0] n);
    int k;
    @(posedge CLK_SYS);
    se_n <= n;
    se_go <= 1'b1;
    @(posedge CLK_SYS);
    se_go <= 1'b0;
    for (k = 0; k < 20000 && se_busy; k++) @(posedge CLK_SYS);
    chk("pulse_train_done", 8'h00, {7'h0, se_busy});
    // a quiet line past the longest period resets the counters, so each train counts from zero
    repeat (60) @(posedge CLK_SYS);
  endtask
  task automatic watch(output int n_o, output int n_a);
    n_o = 0;
    n_a = 0;
    repeat (40) begin
      @(posedge CLK_SYS);
      #1 n_o += (out_line === 1'b1);
      n_a += (aux_o === 1'b1);
    end
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd(ADDR_WIRE_CTRL, v); chk("ctrl_reset", WIRE_CTRL_RESET, v);
    rd(ADDR_ROUTE_CFG, v); chk("cfg_reset", ROUTE_CFG_RESET, v);
    rd(16'h6115, v); chk("unmapped", 8'h00, v);
    wr(ADDR_WIRE_CTRL, 8'hfc); // bits 7:3 read-only, no counting
    rd(ADDR_WIRE_CTRL, v); chk("ctrl_ro", 8'h04, v);
    wr(16'h6115, 8'h55);
    rd(16'h6115, v); chk("unmapped_wr", 8'h00, v);
    wr(ADDR_WIRE_CTRL, 8'h00);
  endtask
  task automatic t_count(logic sel, logic [7:0] below, logic [7:0] above);
    logic [7:0] v;
    logic [7:0] c;
    c = {6'h0, sel, 1'b1};
    wr(ADDR_IRQ_MASK, {7'h0, ~sel});
    wr(ADDR_WIRE_CTRL, c);
    if (sel) send(8'd32);
    if (sel) rd(ADDR_WIRE_CTRL, v);
    if (sel) chk("long_not_short", c, v);
    send(below);
    rd(ADDR_WIRE_CTRL, v); chk("below_limit", c, v);
    send(above);
    rd(ADDR_WIRE_CTRL, v); chk("at_limit", c | 8'h08, v);
    chk("irq", {7'h0, ~sel}, {7'h0, irq});
    rd(ADDR_IRQ_STATUS, v); chk("status", 8'h01, v);
    wr(ADDR_IRQ_STATUS, 8'h01);
    #1 chk("irq_cleared", 8'h00, {7'h0, irq});
    wr(ADDR_WIRE_CTRL, 8'h00);
    rd(ADDR_WIRE_CTRL, v); chk("flag_clear", 8'h00, v);
  endtask
  task automatic t_route();
    logic [7:0] v;
    int n_o, n_a;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_ROUTE_CFG, 8'h0c | 8'(r));
      repeat (8) @(posedge CLK_SYS);
      watch(n_o, n_a);
      chk("out_toggles", {7'h0, r == 1 || r == 2}, {7'h0, n_o > 0 && n_o < 40});
      chk("aux_toggles", 8'h01, {7'h0, aux_oe === 1'b1 && n_a > 0 && n_a < 40});
    end
    wr(ADDR_ROUTE_CFG, 8'h0d);
    demod <= 1'b1;
    repeat (100) @(posedge CLK_SYS);
    rd(ADDR_LINE_STATE, v); chk("filter_delay", 8'h00, v & 8'h02);
    repeat (500) @(posedge CLK_SYS);
    rd(ADDR_LINE_STATE, v); chk("filter_out", 8'h02, v & 8'h02);
    wr(ADDR_ROUTE_CFG, 8'h20);
    repeat (8) @(posedge CLK_SYS);
    rd(ADDR_LINE_STATE, v); chk("idle_view", 8'h08, v & 8'h0c);
    wr(ADDR_ROUTE_CFG, 8'h00);
    repeat (8) @(posedge CLK_SYS);
    rd(ADDR_LINE_STATE, v); chk("aux_view", 8'h00, v & 8'h08);
  endtask
  task automatic t_manch();
    logic [7:0] v;
    int n0;
    wr(ADDR_IRQ_MASK, 8'h06);
    wr(ADDR_ROUTE_CFG, 8'h45);
    se_manch <= 1'b1;
    n0 = ant_rises;
    send(8'ha5);
    chk("antenna_pulses", 8'h20, 8'(ant_rises - n0));
    rd(ADDR_IRQ_STATUS, v); chk("rx_byte_only", 8'h02, v);
    rd(ADDR_RX_DATA, v); chk("rx_byte", 8'ha5, v);
    repeat (1100) @(posedge CLK_SYS);
    rd(ADDR_IRQ_STATUS, v); chk("rx_frame_end", 8'h06, v);
    chk("rx_irq", 8'h01, {7'h0, irq});
    wr(ADDR_IRQ_STATUS, 8'h06);
    wr(ADDR_ROUTE_CFG, 8'h00);
    se_manch <= 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==================== sequence ====================
  initial begin
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_regs();
    t_count(1'b0, 8'd30, 8'd32);
    t_count(1'b1, 8'd126, 8'd128);
    t_route();
    t_manch();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    miscompares++;
    end_sim();
  end
endmodule // testbench

// ---- include/swi_pkg.sv ----
// package: constants, register map and types of the secure wired interface
package swi_pkg;

  // ==================== clock and timing ====================
  localparam int CLK_PERIOD_NS   = 10;
  localparam int FREQ_MAX_KHZ    = 12000;
  localparam int FREQ_MIN_KHZ    = 2000;
  // shortest accepted period rounds up, longest rounds down
  localparam int PER_MIN_CYC     = (1000000 + FREQ_MAX_KHZ * CLK_PERIOD_NS - 1) / (FREQ_MAX_KHZ * CLK_PERIOD_NS);
  localparam int PER_MAX_CYC     = 1000000 / (FREQ_MIN_KHZ * CLK_PERIOD_NS);
  localparam int BIT_TIME_NS     = 4720;
  localparam int FILT_CYC        = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int HALF_BIT_EDGES  = 64;

  // ==================== counters ====================
  localparam int CNT_LIMIT_SHORT = 31;
  localparam int CNT_LIMIT_LONG  = 127;

  // ==================== register map ====================
  localparam logic [15:0] ADDR_WIRE_CTRL   = 16'h610e;
  localparam logic [15:0] ADDR_ROUTE_CFG   = 16'h6110;
  localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h6111;
  localparam logic [15:0] ADDR_IRQ_MASK    = 16'h6112;
  localparam logic [15:0] ADDR_RX_DATA     = 16'h6113;
  localparam logic [15:0] ADDR_LINE_STATE  = 16'h6114;

  localparam int BIT_CNT_ENABLE  = 0;
  localparam int BIT_CNT_SELECT  = 1;
  localparam int BIT_CNT_FLAG    = 3;
  localparam logic [7:0] WIRE_CTRL_RESET = 8'h00;
  localparam logic [7:0] WIRE_CTRL_WMASK = 8'h07;

  localparam logic [7:0] ROUTE_CFG_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET  = 8'h00;
  localparam int IRQ_BIT_COUNTER = 0;
  localparam int IRQ_BIT_RX_BYTE = 1;
  localparam int IRQ_BIT_RX_END  = 2;
  localparam int IRQ_WIDTH       = 3;

  // tx_route_select codes
  localparam logic [1:0] TX_ROUTE_OFF    = 2'h0;
  localparam logic [1:0] TX_ROUTE_XOR    = 2'h1;
  localparam logic [1:0] TX_ROUTE_MILLER = 2'h2;
  localparam logic [1:0] TX_ROUTE_RAW    = 2'h3;

  typedef struct packed {
    logic       reserved;
    logic       scheme_a;                    // 1: signal-in decoded as manchester subcarrier
    logic       idle_mask;
    logic       driver_mix_enable;
    logic       aux_clock_route_enable;
    logic       secure_clock_source_choice;  // 1: internal oscillator, 0: field clock
    logic [1:0] tx_route_select;
  } swi_route_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } swi_bus_req_t;

  typedef enum logic [2:0] {
    DEC_IDLE   = 3'b001,
    DEC_FIRST  = 3'b010,
    DEC_SECOND = 3'b100
  } swi_dec_state_t;

endpackage : swi_pkg
